// >>> ppdc_regs.vh
// Constants for the pipelined presettable down-counter.
// Assumes inclusion by bare name from the counter design files.
`ifndef PPDC_REGS_VH
`define PPDC_REGS_VH

// Bits per section
`define PPDC_SEC_W        2
// Default number of sections, forty bits in all
`define PPDC_NSEC         20
// Section count reset value
`define PPDC_SEC_RST      2'h0
// Carry and pipeline flop reset value
`define PPDC_PIPE_RST     1'b0
// Active-low load strobe reset value: active, forces a load
`define PPDC_STROBE_RST   1'b0
// Final state detect reset value, mirrors the active strobe
`define PPDC_FINAL_RST    1'b1
// Section state decoded as final
`define PPDC_STATE_ZERO   2'h0
// Section state decoded one count before final
`define PPDC_STATE_ONE    2'h1
// Rated count clock in MHz
`define PPDC_RATE_MHZ     40
// Least legal preset value for a twenty-bit counter
`define PPDC_MIN_PRESET   10

`endif

// >>> ppdc_dibit.v
// One two-bit presettable down-counter section with carry and decode flops.
// Assumes one clock, asynchronous active-low reset, and a shared count enable.
`timescale 1ns/1ps
`include "ppdc_regs.vh"

module ppdc_dibit #(
   parameter SW = `PPDC_SEC_W
) (
   mclk,
   nrst,
   countEn,
   carryIn,
   loadEn,
   presetBits,
   decodeChainIn,
   secQ,
   carryOut,
   decodeChainOut,
   stateOneDet
);
   input  wire          mclk;
   input  wire          nrst;
   input  wire          countEn;
   input  wire          carryIn;
   input  wire          loadEn;
   input  wire [SW-1:0] presetBits;
   input  wire          decodeChainIn;
   output wire [SW-1:0] secQ;
   output wire          carryOut;
   output wire          decodeChainOut;
   output wire          stateOneDet;

   reg [SW-1:0] sec_q;
   reg [SW-1:0] sec_d;
   reg          carry_q;
   reg          carry_d;
   reg          chain_q;
   reg          chain_d;

   // Compares the section state with a constant
   function isState;
      input [SW-1:0] val;
      input [SW-1:0] cmpVal;
      begin
         isState = (val == cmpVal);
      end
   endfunction

   always @* begin
      sec_d   = sec_q;
      carry_d = 1'b0;
      chain_d = isState(sec_q, `PPDC_STATE_ZERO) & decodeChainIn & ~loadEn;
      if (loadEn) begin
         sec_d   = presetBits;
         carry_d = 1'b0;
      end else if (carryIn) begin
         sec_d   = sec_q - {{(SW-1){1'b0}}, 1'b1};
         carry_d = isState(sec_q, `PPDC_STATE_ZERO);
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sec_q   <= `PPDC_SEC_RST;
         carry_q <= `PPDC_PIPE_RST;
         chain_q <= `PPDC_PIPE_RST;
      end else if (countEn) begin
         sec_q   <= sec_d;
         carry_q <= carry_d;
         chain_q <= chain_d;
      end
   end

   assign secQ           = sec_q;
   assign carryOut       = carry_q;
   assign decodeChainOut = chain_q;
   assign stateOneDet    = isState(sec_q, `PPDC_STATE_ONE) & decodeChainIn;
endmodule

// >>> ppdc_counter.v
// Pipelined presettable binary down-counter built from two-bit sections.
// Assumes countEn, preset data and splitMode are synchronous to mclk and
// that the preset source never loads values too small for the decode pipeline.
`timescale 1ns/1ps
`include "ppdc_regs.vh"

// What this block does
// - Presettable binary down-counter up to forty bits, counting each enabled clock edge.
// - Optionally splits into two independent twenty-bit counters.
// - Built from two-bit sections with carry in, load and two data inputs.
// - A section reports final state when zero and the higher decode input is active.
// - Final-state decoding chains from the top section down to the lowest.
// - Every counter bit takes part in detecting the final state.
// - Lowest section decodes state one and drives the load strobe for all sections; when split, the lowest high-half section drives the high half.
// - Carry flop sets when carry in is active and the section is zero.
// - A set carry flop stays set one clock and feeds the next section up.
// - Toggling of higher sections is delayed through the carry pipeline.
// - Section n lags the binary sequence by n clocks; final detection stays correct.
// - Carry path and final-state decode path are kept separate.
// - Every fast path is a single logic level; speed independent of length.
// - Decode pipeline flops, gated by the strobe, drop detection one clock after it.
// - Lowest load flop decodes state one; active-low strobe so reset forces loading.
module ppdc_counter #(
   parameter NSEC = `PPDC_NSEC,
   parameter SW   = `PPDC_SEC_W
) (
   mclk,
   nrst,
   countEn,
   splitMode,
   presetData,
   countQ,
   finalStateDetect,
   presetLoadStrobeN
);
   localparam NB   = NSEC * SW;
   localparam HALF = NSEC / 2;

   input  wire          mclk;
   input  wire          nrst;
   input  wire          countEn;
   input  wire          splitMode;
   input  wire [NB-1:0] presetData;
   output wire [NB-1:0] countQ;
   output wire [1:0]    finalStateDetect;
   output wire [1:0]    presetLoadStrobeN;

   wire [NSEC-1:0] carryS;
   wire [NSEC-1:0] carryInS;
   wire [NSEC-1:0] chainInS;
   wire [NSEC-1:0] chainOutS;
   wire [NSEC-1:0] oneDetS;
   wire [NSEC-1:0] loadS;
   wire            loadLo;
   wire            loadHi;

   reg [1:0] strobeN_q;
   reg [1:0] strobeN_d;
   reg [1:0] final_q;
   reg [1:0] final_d;
   reg       split_q;

   // Next active-low strobe: fires one count before final, never twice in a row
   function nextStrobeN;
      input oneDet;
      input loading;
      begin
         nextStrobeN = ~(oneDet & ~loading);
      end
   endfunction

   // Load strobes for the low half and, when split, the high half
   assign loadLo = ~strobeN_q[0];
   assign loadHi = ~strobeN_q[1];

   genvar i;
   generate
      for (i = 0; i < NSEC; i = i + 1) begin : gSec
         if (i == 0) begin : gLow
            assign carryInS[i] = 1'b1;
         end else if (i == HALF) begin : gMidCarry
            assign carryInS[i] = split_q ? 1'b1 : carryS[i-1];
         end else begin : gCarry
            assign carryInS[i] = carryS[i-1];
         end

         if (i == NSEC - 1) begin : gTop
            assign chainInS[i] = 1'b1;
         end else if (i == HALF - 1) begin : gMidChain
            assign chainInS[i] = split_q ? 1'b1 : chainOutS[i+1];
         end else begin : gChain
            assign chainInS[i] = chainOutS[i+1];
         end

         if (i >= HALF) begin : gLoadHi
            assign loadS[i] = split_q ? loadHi : loadLo;
         end else begin : gLoadLo
            assign loadS[i] = loadLo;
         end

         ppdc_dibit #(
            .SW             (SW)
         ) uSec (
            .mclk           (mclk),
            .nrst           (nrst),
            .countEn        (countEn),
            .carryIn        (carryInS[i]),
            .loadEn         (loadS[i]),
            .presetBits     (presetData[i*SW +: SW]),
            .decodeChainIn  (chainInS[i]),
            .secQ           (countQ[i*SW +: SW]),
            .carryOut       (carryS[i]),
            .decodeChainOut (chainOutS[i]),
            .stateOneDet    (oneDetS[i])
         );
      end
   endgenerate

   // Load flops decode state one of the lowest section, or of section HALF for the high half when split, gated by the strobe itself
   always @* begin
      strobeN_d[0] = nextStrobeN(oneDetS[0], loadLo);
      if (split_q) begin
         strobeN_d[1] = nextStrobeN(oneDetS[HALF], loadHi);
      end else begin
         strobeN_d[1] = strobeN_d[0];
      end
      final_d = ~strobeN_d;
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         strobeN_q <= {2{`PPDC_STROBE_RST}};
         final_q   <= {2{`PPDC_FINAL_RST}};
      end else if (countEn) begin
         strobeN_q <= strobeN_d;
         final_q   <= final_d;
      end
   end

   // Mode is taken only on a low-half load, so when split a running high-half count can be torn apart
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         split_q <= 1'b0;
      end else if (countEn && loadLo) begin
         split_q <= splitMode;
      end
   end

   assign finalStateDetect  = final_q;
   assign presetLoadStrobeN = strobeN_q;
endmodule

// >>> ppdc_monitor.sv
// Port checker for the pipelined down-counter.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module ppdc_monitor #(parameter NSEC = 20, parameter SW = 2, parameter NB = NSEC * SW) (
   input logic          mclk,
   input logic          nrst,
   input logic          countEn,
   input logic          splitMode,
   input logic [NB-1:0] presetData,
   input logic [NB-1:0] countQ,
   input logic [1:0]    finalStateDetect,
   input logic [1:0]    presetLoadStrobeN
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_run; countEn && &presetLoadStrobeN; endsequence
   sequence s_wrap; s_run ##0 countQ[1:0] == 2'h0; endsequence
   a_final_mirror: assert property (finalStateDetect == ~presetLoadStrobeN) else $error("final mirror");
   a_strobe_once: assert property (countEn && !presetLoadStrobeN[0] |=> presetLoadStrobeN[0]) else $error("strobe");
   a_idle_hold: assert property (!countEn |=> $stable(countQ) && $stable(presetLoadStrobeN)) else $error("idle");
   a_load_all: assert property (countEn && presetLoadStrobeN == 2'h0 |=> countQ == $past(presetData)) else $error("load");
   a_low_dec: assert property (s_run |=> countQ[1:0] == $past(countQ[1:0]) - 2'h1) else $error("low section");
   a_load_one: assert property (countEn && countQ == 1 |=> !presetLoadStrobeN[0]) else $error("load at one");
   a_no_early: assert property (countEn && !splitMode && countQ != 1 |=> presetLoadStrobeN[0]) else $error("early");
   a_carry_lag: assert property (s_wrap ##1 s_run |=> countQ[3:2] == $past(countQ[3:2]) - 2'h1) else $error("carry");
endmodule
bind ppdc_counter ppdc_monitor #(.NSEC(NSEC), .SW(SW)) uMon (.mclk(mclk), .nrst(nrst), .countEn(countEn),
   .splitMode(splitMode), .presetData(presetData), .countQ(countQ), .finalStateDetect(finalStateDetect),
   .presetLoadStrobeN(presetLoadStrobeN));

// >>> ppdc_synth_src.sv
// Synthesizer model: count enable and static preset value.
// Assumes the bench sets gap and presetIn; outputs move 1 ns after mclk rises.
`timescale 1ns/1ps
module ppdc_synth_src #(parameter NB = 8) (
   input  logic          mclk,
   input  logic          gap,
   input  logic [NB-1:0] presetIn,
   output logic          countEn,
   output logic [NB-1:0] presetData
);
   initial begin
      countEn = 1'b1;
      presetData = '0;
   end
   always @(posedge mclk) begin
      #1;
      countEn = gap ? ~countEn : 1'b1;
      presetData = presetIn;
   end
endmodule

// >>> tb.sv
// Self-checking bench for an eight-bit counter of four sections.
// Assumes the synthesizer model drives count enable and preset.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin num_checks++; if ((e) !== (s)) begin num_errors++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, s); end end
module tb;
   logic       mclk, nrst, splitMode, gap, countEn;
   logic [7:0] presetIn, presetData, countQ;
   logic [1:0] finalStateDetect, presetLoadStrobeN;
   int         num_errors = 0;
   int         num_checks = 0;
   int         n;
   // Preset, gapped enable, enabled edges per load
   int         rows [5][3] = '{'{8'h0A, 0, 11}, '{8'h25, 0, 38}, '{8'h80, 0, 129}, '{8'hFF, 0, 256}, '{8'h25, 1, 38}};
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   ppdc_synth_src #(.NB(8)) uSrc (.mclk(mclk), .gap(gap), .presetIn(presetIn), .countEn(countEn),
      .presetData(presetData));
   ppdc_counter #(.NSEC(4)) DUT (.mclk(mclk), .nrst(nrst), .countEn(countEn), .splitMode(splitMode),
      .presetData(presetData), .countQ(countQ), .finalStateDetect(finalStateDetect),
      .presetLoadStrobeN(presetLoadStrobeN));
   task close_out;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Enabled edges from one load of strobe i to the next
   task per(input int i, output int k);
      k = 0;
      while (!(countEn && !presetLoadStrobeN[i]) && k < 600) begin
         @(negedge mclk);
         k++;
      end
      k = 0;
      do begin
         @(negedge mclk);
         k += countEn;
      end while (!(countEn && !presetLoadStrobeN[i]) && k < 600);
   endtask
   task rst_chk;
      @(posedge mclk) #1 nrst = 1'b0;
      @(negedge mclk);
      `CHK("countQ", 8'h00, countQ)
      `CHK("strobe", 2'h0, presetLoadStrobeN)
      `CHK("final", 2'h3, finalStateDetect)
      repeat (9) @(posedge mclk);
      @(posedge mclk) #1 nrst = 1'b1;
   endtask
   initial begin
      nrst = 1'b0;
      splitMode = 1'b0;
      gap = 1'b0;
      presetIn = 8'h0A;
      rst_chk();
      foreach (rows[r]) begin
         @(posedge mclk) #1;
         presetIn = rows[r][0];
         gap = rows[r][1];
         @(negedge mclk);
         per(0, n);
         per(0, n);
         `CHK("period", rows[r][2], n)
         @(negedge mclk);
         `CHK("loaded", rows[r][0], countQ)
      end
      rst_chk();
      @(posedge mclk) #1;
      gap = 1'b0;
      presetIn = 8'hAC;
      splitMode = 1'b1;
      @(negedge mclk);
      per(0, n);
      per(1, n);
      per(1, n);
      `CHK("high period", 11, n)
      per(0, n);
      `CHK("low period", 13, n)
      close_out();
   end
   initial begin
      #2000000;
      num_errors++;
      close_out();
   end
endmodule
